// ==== verilog/ocd_pkg.sv ====
// Shared constants, settings layout and carrier types for the overcurrent and direction logic.
package ocd_pkg;
	localparam int CLK_PERIOD_NS = 40;
	localparam int TICK_PERIOD_NS = 1_000_000;
	localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int DIR_SETTLE_MS = 20;
	localparam int DT_BASE_MS = 100;
	localparam int DELAY_UNIT_MS = 10;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_TOC = 8'h04;
	localparam logic [7:0] ADDR_TOC_TDM = 8'h08;
	localparam logic [7:0] ADDR_IOC1 = 8'h0C;
	localparam logic [7:0] ADDR_IOC2 = 8'h10;
	localparam logic [7:0] ADDR_DIR = 8'h14;
	localparam logic [7:0] ADDR_GND = 8'h18;
	localparam logic [7:0] ADDR_USER_K = 8'h1C;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	localparam logic [11:0] PKP_MIN = 12'h005;
	localparam logic [11:0] PKP_MAX = 12'h7D0;
	localparam logic [11:0] PKP_RST = 12'h064;
	localparam logic [11:0] SPKP_MAX = 12'hBB8;
	localparam logic [11:0] SPKP_RST = 12'h3E8;
	localparam logic [12:0] TDM_MIN = 13'h0005;
	localparam logic [12:0] TDM_MAX = 13'h1388;
	localparam logic [12:0] TDM_RST = 13'h0064;
	localparam logic [14:0] DLY_MAX = 15'h7530;
	localparam logic [8:0] MTA_MAX = 9'h167;
	localparam logic [8:0] MTA_RST = 9'h01E;
	localparam logic [7:0] MINPOL_MAX = 8'h7D;
	localparam logic [7:0] MINPOL_RST = 8'h05;
	localparam logic [15:0] USER_K_RST = 16'h0064;
	localparam logic [10:0] ANG_FULL = 11'h168;
	localparam logic [10:0] ANG_HALF = 11'h0B4;
	localparam logic [10:0] ANG_QTR = 11'h05A;
	localparam logic [10:0] ANG_3QTR = 11'h10E;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [3:0] {
		C_ANSI_EI = 4'h0, C_ANSI_VI = 4'h1, C_ANSI_MI = 4'h2, C_ANSI_NI = 4'h3,
		C_DEF_TIME = 4'h4, C_IEC_A = 4'h5, C_IEC_B = 4'h6, C_IEC_C = 4'h7,
		C_IEC_SI = 4'h8, C_IAC_EI = 4'h9, C_IAC_VI = 4'hA, C_IAC_I = 4'hB,
		C_IAC_SI = 4'hC, C_USER = 4'hD, C_CUSTOM_A = 4'hE, C_CUSTOM_B = 4'hF
	} curve_e;
	// Energy scale per standard family; the user and custom tables take user_k instead.
	localparam logic [15:0] CURVE_K [13] = '{16'h0190, 16'h00C8, 16'h0064, 16'h0050, 16'h0001,
		16'h0046, 16'h00A0, 16'h0140, 16'h0019, 16'h01A0, 16'h00D0, 16'h0070, 16'h0020};
	typedef enum logic [1:0] {DSEL_OFF = 2'h0, DSEL_FWD = 2'h1, DSEL_REV = 2'h2} dir_sel_e;
	typedef enum logic [1:0] {FN_OFF = 2'h0, FN_LATCH = 2'h1, FN_ALARM = 2'h2, FN_TRIP = 2'h3} func_e;
	typedef enum logic [1:0] {DM_OFF = 2'h0, DM_ALARM = 2'h1, DM_LATCH = 2'h2, DM_CONTROL = 2'h3} dir_mode_e;
	typedef struct packed {
		logic valid;
		logic [2:0][15:0] i_mag;
		logic [2:0][8:0] i_ang;
		logic [2:0][15:0] v_mag;
		logic [2:0][8:0] v_ang;
		logic [15:0] g_mag;
	} meas_s;
	typedef struct packed {
		logic [2:0] toc_pickup;
		logic toc_operate;
		logic [1:0] ioc_pickup;
		logic [1:0] ioc_trip;
		logic [1:0] ioc_alarm;
		logic gnd_pickup;
		logic gnd_operate;
		logic [2:0] dir_forward;
		logic [2:0] dir_undefined;
		logic dir_alarm;
	} flags_s;
endpackage : ocd_pkg

// ==== verilog/overcurrent_direction_logic.sv ====
// Phase and ground overcurrent elements with phase directional supervision and AXI4-Lite settings.
// How it works
// - Phase timed pickup 0.05 to 20.00 CT.
// - Timed element curve selectable, default extremely inverse.
// - Time dial 0.05 to 50.00 scales times.
// - Instantaneous reset zeroes energy; linear option exists.
// - Phase timed element operates only in chosen direction.
// - Two instantaneous stages, three phases each.
// - Instantaneous pickup 0.05 to 20.00 CT.
// - Instantaneous delay 0 to 300 s.
// - Stage mode disabled, latched alarm, alarm, trip.
// - Phase polarized by opposite line voltage plus angle.
// - Low polarizing voltage makes direction undefined.
// - Minimum polarizing voltage 0.00 to 1.25 VT.
// - Torque angle 0 to 359, default 30.
// - Alarm mode follows any reverse phase.
// - Latched alarm holds until reset command.
// - Control mode never drives the alarm.
// - Undefined direction blocks directional elements if enabled.
// - Direction reversal confirmed after about 20 ms.
// - Ground timed pickup and operate flags.
// - Ground drops out below 97.5 percent pickup.
// - Definite time is 0.1 s times dial.
// - Sensitive ground build changes ground pickup range.
// - Phase timed settings shared by all three phases, hysteretic dropout.
module overcurrent_direction_logic #(
	parameter int TICK_CYCLES = ocd_pkg::TICK_CYCLES_DEF,
	parameter bit SENSITIVE_GROUND = 1'b0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input ocd_pkg::meas_s meas,
	output ocd_pkg::flags_s flags
);
	import ocd_pkg::*;

	logic acb, blk_undef, toc_lin, gnd_lin, reset_cmd;
	dir_mode_e dir_mode;
	logic [11:0] toc_pkp, gnd_pkp;
	logic [12:0] toc_tdm, gnd_tdm;
	curve_e toc_curve, gnd_curve;
	dir_sel_e toc_dir;
	logic [11:0] ioc_pkp [2];
	func_e ioc_mode [2];
	dir_sel_e ioc_dir [2];
	logic [14:0] ioc_dly [2];
	logic [8:0] max_torque_angle;
	logic [7:0] minpol;
	logic [15:0] user_k;
	logic [31:0] tick_cnt;
	logic tick;
	logic [2:0] fwd, undef, rawf;
	logic [3:0] tpk, top;
	logic [31:0] energy [4];
	logic [5:0] ipk, iop;
	logic [18:0] icnt [6];
	logic [1:0] ioc_latch;
	logic dir_alarm;
	logic wr_en;
	logic [31:0] wr_word, status;

	function automatic logic [31:0] clampv(input logic [31:0] v, lo, hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : clampv

	function automatic logic fwd_of(input logic [8:0] ia, va, m, input logic rev_seq);
		logic [10:0] pol;
		logic [10:0] d;
		pol = (11'(va) + 11'(m) + (rev_seq ? ANG_HALF : 11'h000)) % ANG_FULL;
		d = (11'(ia) + ANG_FULL + ANG_FULL - pol) % ANG_FULL;
		return (d <= ANG_QTR) || (d >= ANG_3QTR);
	endfunction : fwd_of

	function automatic logic permit(input dir_sel_e s, input logic f, u, blk);
		case (s)
			DSEL_FWD: permit = u ? !blk : f;
			DSEL_REV: permit = u ? !blk : !f;
			default: permit = 1'b1;
		endcase
	endfunction : permit

	function automatic logic [31:0] reg_read(input logic [7:0] a);
		case (a)
			ADDR_CTRL: reg_read = {26'h0, gnd_lin, toc_lin, dir_mode, blk_undef, acb};
			ADDR_TOC: reg_read = {6'h0, toc_dir, 4'h0, toc_curve, 4'h0, toc_pkp};
			ADDR_TOC_TDM: reg_read = {19'h0, toc_tdm};
			ADDR_IOC1: reg_read = {1'b0, ioc_dly[0], ioc_dir[0], ioc_mode[0], ioc_pkp[0]};
			ADDR_IOC2: reg_read = {1'b0, ioc_dly[1], ioc_dir[1], ioc_mode[1], ioc_pkp[1]};
			ADDR_DIR: reg_read = {8'h0, minpol, 7'h0, max_torque_angle};
			ADDR_GND: reg_read = {gnd_curve, gnd_tdm[11:0], 4'h0, gnd_pkp};
			ADDR_USER_K: reg_read = {16'h0, user_k};
			ADDR_STATUS: reg_read = status;
			default: reg_read = 32'h0000_0000;
		endcase
	endfunction : reg_read

	function automatic logic mapped(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= ADDR_STATUS);
	endfunction : mapped

	assign status = {13'h0, flags};

	// Write address and data are taken together, so no half-accepted write needs storing.
	assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_wready = s_axi_awready;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_en = s_axi_awready;
	always_comb begin
		wr_word = reg_read(s_axi_awaddr);
		for (int b = 0; b < 4; b++) begin
			if (s_axi_wstrb[b]) begin
				wr_word[8*b +: 8] = s_axi_wdata[8*b +: 8];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_en) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= mapped(s_axi_araddr) ? reg_read(s_axi_araddr) : 32'h0000_0000;
			s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Out-of-range settings are held at the nearest limit rather than refused.
	always_ff @(posedge aclk) begin
		reset_cmd <= wr_en && (s_axi_awaddr == ADDR_CTRL) && wr_word[6];
		if (!aresetn) begin
			acb <= 1'b0;
			blk_undef <= 1'b1;
			dir_mode <= DM_OFF;
			toc_lin <= 1'b0;
			gnd_lin <= 1'b0;
			toc_pkp <= PKP_RST;
			toc_curve <= C_ANSI_EI;
			toc_dir <= DSEL_OFF;
			toc_tdm <= TDM_RST;
			for (int s = 0; s < 2; s++) begin
				ioc_pkp[s] <= PKP_RST;
				ioc_mode[s] <= FN_OFF;
				ioc_dir[s] <= DSEL_OFF;
				ioc_dly[s] <= 15'h0000;
			end
			max_torque_angle <= MTA_RST;
			minpol <= MINPOL_RST;
			gnd_pkp <= SENSITIVE_GROUND ? SPKP_RST : PKP_RST;
			gnd_tdm <= TDM_RST;
			gnd_curve <= C_ANSI_EI;
			user_k <= USER_K_RST;
			reset_cmd <= 1'b0;
		end else if (wr_en) begin
			case (s_axi_awaddr)
				ADDR_CTRL: begin
					acb <= wr_word[0];
					blk_undef <= wr_word[1];
					dir_mode <= dir_mode_e'(wr_word[3:2]);
					toc_lin <= wr_word[4];
					gnd_lin <= wr_word[5];
				end
				ADDR_TOC: begin
					toc_pkp <= 12'(clampv(32'(wr_word[11:0]), 32'(PKP_MIN), 32'(PKP_MAX)));
					toc_curve <= curve_e'(wr_word[19:16]);
					toc_dir <= dir_sel_e'(wr_word[25:24]);
				end
				ADDR_TOC_TDM: toc_tdm <= 13'(clampv(32'(wr_word[12:0]), 32'(TDM_MIN), 32'(TDM_MAX)));
				ADDR_IOC1, ADDR_IOC2: begin
					ioc_pkp[s_axi_awaddr[4]] <= 12'(clampv(32'(wr_word[11:0]), 32'(PKP_MIN),
						32'(PKP_MAX)));
					ioc_mode[s_axi_awaddr[4]] <= func_e'(wr_word[13:12]);
					ioc_dir[s_axi_awaddr[4]] <= dir_sel_e'(wr_word[15:14]);
					ioc_dly[s_axi_awaddr[4]] <= 15'(clampv(32'(wr_word[30:16]), 32'h0,
						32'(DLY_MAX)));
				end
				ADDR_DIR: begin
					max_torque_angle <= 9'(clampv(32'(wr_word[8:0]), 32'h0, 32'(MTA_MAX)));
					minpol <= 8'(clampv(32'(wr_word[23:16]), 32'h0, 32'(MINPOL_MAX)));
				end
				ADDR_GND: begin
					gnd_pkp <= 12'(clampv(32'(wr_word[11:0]), 32'(SENSITIVE_GROUND ? 12'h005 : PKP_MIN),
						32'(SENSITIVE_GROUND ? SPKP_MAX : PKP_MAX)));
					gnd_tdm <= 13'(clampv(32'(wr_word[28:16]), 32'(TDM_MIN), 32'(TDM_MAX)));
					gnd_curve <= curve_e'(wr_word[31:28] == 4'h0 ? 4'h0 : wr_word[31:28]);
				end
				ADDR_USER_K: user_k <= wr_word[15:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || tick) begin
			tick_cnt <= 32'h0000_0000;
		end else begin
			tick_cnt <= tick_cnt + 32'h0000_0001;
		end
	end
	assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

	// Direction: undefined acts at once, a forward/reverse flip waits out the settle time.
	for (genvar p = 0; p < 3; p++) begin : g_dir
		logic [7:0] settle;
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				undef[p] <= 1'b1;
				rawf[p] <= 1'b1;
			end else if (meas.valid) begin
				undef[p] <= meas.v_mag[(p + 1) % 3] < 16'(minpol);
				rawf[p] <= fwd_of(meas.i_ang[p], meas.v_ang[(p + 1) % 3], max_torque_angle, acb);
			end
		end
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				fwd[p] <= 1'b1;
				settle <= 8'h00;
			end else if (rawf[p] == fwd[p] || undef[p]) begin
				settle <= 8'h00;
			end else if (tick) begin
				if (settle == 8'(DIR_SETTLE_MS - 1)) begin
					fwd[p] <= rawf[p];
					settle <= 8'h00;
				end else begin
					settle <= settle + 8'h01;
				end
			end
		end
	end

	// Channels 0..2 are the phase timed elements, channel 3 the ground timed element.
	for (genvar c = 0; c < 4; c++) begin : g_toc
		logic [15:0] cur, pickup_threshold, held;
		logic [12:0] tdm;
		curve_e crv;
		logic lin, ok;
		logic [31:0] thr, step;
		assign cur = (c < 3) ? meas.i_mag[c % 3] : meas.g_mag;
		assign pickup_threshold = 16'((c < 3) ? toc_pkp : gnd_pkp);
		assign tdm = (c < 3) ? toc_tdm : gnd_tdm;
		assign crv = (c < 3) ? toc_curve : gnd_curve;
		assign lin = (c < 3) ? toc_lin : gnd_lin;
		assign ok = (c < 3) ? permit(toc_dir, fwd[c % 3], undef[c % 3], blk_undef) : 1'b1;
		always_comb begin
			if (crv == C_DEF_TIME) begin
				thr = 32'(tdm) * 32'(DT_BASE_MS) / 32'd100;
				step = 32'h0000_0001;
			end else begin
				thr = 32'(tdm) * 32'((crv >= C_USER) ? user_k : CURVE_K[crv]);
				// A current inside the drop-out band keeps pickup but adds no energy.
				step = 32'((held > pickup_threshold) ? held - pickup_threshold : 16'h0000);
			end
		end
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				tpk[c] <= 1'b0;
				held <= 16'h0000;
			end else if (meas.valid) begin
				// Between strobes the measurement is not valid, so the last sample is kept.
				held <= cur;
				if (cur > pickup_threshold) begin
					tpk[c] <= 1'b1;
				end else if ((20'(cur) * 20'd40) < (20'(pickup_threshold) * 20'd39)) begin
					tpk[c] <= 1'b0;
				end
			end
		end
		always_ff @(posedge aclk) begin
			// Instantaneous reset must not wait for the next tick, or a quick re-pickup keeps energy.
			if (!aresetn || (!tpk[c] && !lin)) begin
				energy[c] <= 32'h0000_0000;
			end else if (tick) begin
				if (tpk[c] && ok) begin
					energy[c] <= (energy[c] >= thr) ? energy[c] : energy[c] + step;
				end else if (!tpk[c]) begin
					energy[c] <= (energy[c] > 32'(tdm)) ? energy[c] - 32'(tdm) : 32'h0000_0000;
				end
			end
		end
		assign top[c] = tpk[c] && ok && (energy[c] >= thr);
	end

	// Six instantaneous elements: index is stage times three plus phase.
	for (genvar k = 0; k < 6; k++) begin : g_ioc
		localparam int S = k / 3;
		localparam int P = k % 3;
		logic ok;
		assign ok = permit(ioc_dir[S], fwd[P], undef[P], blk_undef);
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				ipk[k] <= 1'b0;
			end else if (meas.valid) begin
				if (meas.i_mag[P] > 16'(ioc_pkp[S])) begin
					ipk[k] <= 1'b1;
				end else if ((20'(meas.i_mag[P]) * 20'd40) < (20'(ioc_pkp[S]) * 20'd39)) begin
					ipk[k] <= 1'b0;
				end
			end
		end
		always_ff @(posedge aclk) begin
			if (!aresetn || !ipk[k] || !ok) begin
				icnt[k] <= 19'h0_0000;
			end else if (tick && !iop[k]) begin
				icnt[k] <= icnt[k] + 19'h0_0001;
			end
		end
		assign iop[k] = ipk[k] && ok && (icnt[k] >= 19'(ioc_dly[S]) * 19'(DELAY_UNIT_MS));
	end

	for (genvar s = 0; s < 2; s++) begin : g_latch
		always_ff @(posedge aclk) begin
			if (!aresetn || ioc_mode[s] != FN_LATCH) begin
				ioc_latch[s] <= 1'b0;
			end else if (|iop[3*s +: 3]) begin
				ioc_latch[s] <= 1'b1;
			end else if (reset_cmd) begin
				ioc_latch[s] <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dir_alarm <= 1'b0;
		end else begin
			case (dir_mode)
				DM_ALARM: dir_alarm <= (fwd | undef) != 3'h7;
				DM_LATCH: dir_alarm <= ((fwd | undef) != 3'h7) || (dir_alarm && !reset_cmd);
				default: dir_alarm <= 1'b0;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags <= '0;
		end else begin
			flags.toc_pickup <= tpk[2:0];
			flags.toc_operate <= |top[2:0];
			flags.gnd_pickup <= tpk[3];
			flags.gnd_operate <= top[3];
			for (int s = 0; s < 2; s++) begin
				flags.ioc_pickup[s] <= (ioc_mode[s] != FN_OFF) && |ipk[3*s +: 3];
				flags.ioc_trip[s] <= (ioc_mode[s] == FN_TRIP) && |iop[3*s +: 3];
				flags.ioc_alarm[s] <= ((ioc_mode[s] == FN_ALARM) && |iop[3*s +: 3]) || ioc_latch[s];
			end
			flags.dir_forward <= fwd;
			flags.dir_undefined <= undef;
			flags.dir_alarm <= dir_alarm;
		end
	end

	AST_PKP_RANGE: assert property (@(posedge aclk) disable iff (!aresetn)
		toc_pkp >= PKP_MIN && toc_pkp <= PKP_MAX) else $error("Timed pickup out of range.");
	AST_TDM_RANGE: assert property (@(posedge aclk) disable iff (!aresetn)
		toc_tdm >= TDM_MIN && toc_tdm <= TDM_MAX) else $error("Time dial out of range.");
	AST_INST_RESET: assert property (@(posedge aclk) disable iff (!aresetn)
		tick && !tpk[0] && !toc_lin |=> energy[0] == 32'h0) else $error("Energy not cleared.");
	AST_UNDEF: assert property (@(posedge aclk) disable iff (!aresetn)
		meas.valid && meas.v_mag[1] < 16'(minpol) |=> undef[0]) else $error("Direction not undefined.");
	AST_BLOCK: assert property (@(posedge aclk) disable iff (!aresetn)
		undef[0] && blk_undef && toc_dir != DSEL_OFF |-> !top[0]) else $error("Undefined not blocked.");
	AST_IOC_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
		ioc_mode[0] == FN_OFF ##1 ioc_mode[0] == FN_OFF |=> !flags.ioc_trip[0] && !flags.ioc_alarm[0])
		else $error("Disabled stage acted.");
	AST_LATCH_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
		dir_mode == DM_LATCH && dir_alarm && !reset_cmd |=> dir_alarm) else $error("Latch lost.");
	AST_CONTROL: assert property (@(posedge aclk) disable iff (!aresetn)
		dir_mode == DM_CONTROL |=> !dir_alarm) else $error("Control mode drove alarm.");
	AST_GND_DROP: assert property (@(posedge aclk) disable iff (!aresetn)
		meas.valid && (22'(meas.g_mag) * 22'd40 < 22'(gnd_pkp) * 22'd39) |=> !tpk[3])
		else $error("Ground did not drop out.");
	COV_TOC_OP: cover property (@(posedge aclk) disable iff (!aresetn) $rose(flags.toc_operate));
	COV_IOC_TRIP: cover property (@(posedge aclk) disable iff (!aresetn) $rose(flags.ioc_trip[0]));
	COV_DIR_REV: cover property (@(posedge aclk) disable iff (!aresetn) $fell(fwd[0]));
	COV_LATCH_CLR: cover property (@(posedge aclk) disable iff (!aresetn) $fell(dir_alarm));
endmodule : overcurrent_direction_logic

// ==== tb/meas_source.sv ====
// Model of the measurement front end that feeds processing strobes to the protection logic.
module meas_source #(
	parameter int PERIOD = 3
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire ocd_pkg::meas_s sample,
	output ocd_pkg::meas_s meas
);
	timeunit 1ns;
	timeprecision 1ns;
	import ocd_pkg::*;
	int cnt;
	// Between strobes the fields are scrambled, so stale data cannot pass for a sample.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt <= 0;
			meas <= '0;
		end else begin
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
			if (cnt == 0) begin
				meas <= sample;
				meas.valid <= 1'b1;
			end else begin
				meas <= ~meas;
				meas.valid <= 1'b0;
			end
		end
	end
endmodule : meas_source

// ==== tb/overcurrent_direction_logic_test.sv ====
// Self-checking bench for the overcurrent and direction logic.
module overcurrent_direction_logic_test;
	timeunit 1ns;
	timeprecision 1ns;
	import ocd_pkg::*;
	localparam int TICK = 10;
	localparam int SPAN = 15 * TICK;
	localparam int LONG = 30 * TICK;
	localparam logic [18:0] TPKB = 19'h2_0000, GPK = 19'h0_0100, TOP = 19'h0_8000;
	localparam logic [18:0] GOP = 19'h0_0080, IPK = 19'h0_6000, IALM2 = 19'h0_0400;
	localparam logic [18:0] ITRIP1 = 19'h0_0800, FWD = 19'h0_0070, ALM = 19'h0_0001;
	localparam logic [18:0] UNDA = 19'h0_0002, NONE = 19'h0_0000;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	meas_s smp;
	meas_s meas;
	flags_s flags;
	logic [18:0] fv;
	int fails = 0;
	int num_checks = 0;
	logic [7:0] ra [7] = '{ADDR_CTRL, ADDR_TOC, ADDR_TOC_TDM, ADDR_IOC1, ADDR_IOC2,
		ADDR_DIR, ADDR_USER_K};
	logic [31:0] rv [7] = '{32'h0000_0002, 32'h0000_0064, 32'h0000_0064, 32'h0000_0064,
		32'h0000_0064, 32'h0005_001E, 32'h0000_0064};
	// Out-of-range writes come back clamped; the last rows leave the settings used below.
	logic [7:0] wa [12] = '{ADDR_TOC, ADDR_TOC, ADDR_TOC_TDM, ADDR_TOC_TDM, ADDR_IOC1,
		ADDR_DIR, ADDR_DIR, ADDR_TOC, ADDR_TOC_TDM, ADDR_IOC1, ADDR_IOC2, ADDR_GND};
	logic [31:0] wd [12] = '{32'h0000_0000, 32'h0000_0FFF, 32'h0000_0001, 32'h0000_1FFF,
		32'h7FFF_0FFF, 32'h00C8_01FF, 32'h0005_001E, 32'h0004_0064, 32'h0000_0014,
		32'h0002_30C8, 32'h0000_10FA, 32'h4014_0064};
	logic [31:0] we [12] = '{32'h0000_0005, 32'h0000_07D0, 32'h0000_0005, 32'h0000_1388,
		32'h7530_07D0, 32'h007D_0167, 32'h0005_001E, 32'h0004_0064, 32'h0000_0014,
		32'h0002_30C8, 32'h0000_10FA, 32'h4014_0064};
	assign fv = flags;
	initial begin
		forever #20 aclk = ~aclk;
	end
	overcurrent_direction_logic #(.TICK_CYCLES(TICK), .SENSITIVE_GROUND(1'b0)) i_dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.meas(meas), .flags(flags));
	meas_source #(.PERIOD(3)) i_src (.aclk(aclk), .aresetn(aresetn), .sample(smp), .meas(meas));
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check_word
	task automatic check_flags(input logic [18:0] got, input logic [18:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t flags %h exp %h", $time, got, exp);
		end
	endtask : check_flags
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int t;
		logic aw_p, w_p;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw_p = 1'b1;
		w_p = 1'b1;
		for (t = 0; t < 50; t++) begin
			@(posedge aclk);
			if (aw_p && awready) begin
				aw_p = 1'b0;
				awvalid <= 1'b0;
			end
			if (w_p && wready) begin
				w_p = 1'b0;
				wvalid <= 1'b0;
			end
			if (!aw_p && !w_p && bvalid) break;
		end
		if (t == 50) fails++;
		bready <= 1'b0;
		check_word({30'h0, bresp}, {30'h0, er});
	endtask : axi_write
	task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int t;
		logic ar_p;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		ar_p = 1'b1;
		for (t = 0; t < 50; t++) begin
			@(posedge aclk);
			if (ar_p && arready) begin
				ar_p = 1'b0;
				arvalid <= 1'b0;
			end else if (!ar_p && rvalid) begin
				break;
			end
		end
		if (t == 50) fails++;
		rready <= 1'b0;
		check_word(rdata, ed);
		check_word({30'h0, rresp}, {30'h0, er});
	endtask : axi_read
	// A flag that reaches its value inside the quiet span has come too early.
	task automatic wait_flags(input logic [18:0] m, input logic [18:0] e, input int q, input int n);
		int t;
		for (t = 0; t < q; t++) begin
			@(posedge aclk);
			if ((fv & m) === e) begin
				check_flags(fv & m, ~e & m);
				break;
			end
		end
		for (t = 0; t < n && (fv & m) !== e; t++) begin
			@(posedge aclk);
		end
		check_flags(fv & m, e);
	endtask : wait_flags
	task end_of_test;
		if (fails == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_of_test
	initial begin
		#1_000_000;
		fails++;
		end_of_test();
	end
	initial begin
		smp = '0;
		smp.v_mag = {3{16'h0064}};
		smp.i_ang = {3{9'h01E}};
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (ra[i]) axi_read(ra[i], rv[i], RESP_OKAY);
		axi_read(8'h24, 32'h0000_0000, RESP_SLVERR);
		axi_read(8'h06, 32'h0000_0000, RESP_SLVERR);
		axi_write(8'h28, 32'h0000_0001, RESP_SLVERR);
		foreach (wa[i]) begin
			axi_write(wa[i], wd[i], RESP_OKAY);
			axi_read(wa[i], we[i], RESP_OKAY);
		end
		smp.i_mag[1] <= 16'h0065;
		smp.g_mag <= 16'h0065;
		wait_flags(TPKB | GPK, TPKB | GPK, 0, 20);
		smp.i_mag[1] <= 16'h0062;
		smp.g_mag <= 16'h0062;
		repeat (30) @(posedge aclk);
		wait_flags(TPKB | GPK, TPKB | GPK, 0, 0);
		smp.i_mag[1] <= 16'h0061;
		smp.g_mag <= 16'h0061;
		wait_flags(TPKB | GPK, NONE, 0, 20);
		smp.i_mag[1] <= 16'h012C;
		smp.g_mag <= 16'h012C;
		wait_flags(TOP | GOP, TOP | GOP, SPAN, SPAN);
		smp.i_mag[1] <= 16'h0000;
		smp.g_mag <= 16'h0000;
		wait_flags(TOP | GOP, NONE, 0, 20);
		smp.i_mag[1] <= 16'h012C;
		smp.g_mag <= 16'h012C;
		wait_flags(TOP | GOP, TOP | GOP, SPAN, SPAN);
		smp.i_mag[1] <= 16'h0000;
		smp.g_mag <= 16'h0000;
		wait_flags(IPK | ITRIP1, NONE, 0, 20);
		axi_write(ADDR_CTRL, 32'h0000_0042, RESP_OKAY);
		wait_flags(IALM2, NONE, 0, 20);
		smp.i_mag[2] <= 16'h012C;
		wait_flags(IPK | IALM2, IPK | IALM2, 0, 20);
		wait_flags(ITRIP1, ITRIP1, SPAN, SPAN);
		wait_flags(19'h0_1200, NONE, 0, 0);
		smp.i_mag[2] <= 16'h0000;
		wait_flags(IPK | IALM2, IALM2, 0, 20);
		axi_write(ADDR_CTRL, 32'h0000_0042, RESP_OKAY);
		wait_flags(IALM2, NONE, 0, 20);
		axi_write(ADDR_CTRL, 32'h0000_0006, RESP_OKAY);
		smp.v_ang[1] <= 9'h0B4;
		wait_flags(FWD, 19'h0_0060, SPAN, SPAN);
		wait_flags(ALM, ALM, 0, 20);
		smp.v_ang[1] <= 9'h000;
		wait_flags(FWD, FWD, SPAN, SPAN);
		wait_flags(ALM, NONE, 0, 20);
		axi_write(ADDR_CTRL, 32'h0000_000A, RESP_OKAY);
		smp.v_ang[1] <= 9'h0B4;
		wait_flags(FWD | ALM, 19'h0_0061, 0, LONG);
		smp.v_ang[1] <= 9'h000;
		wait_flags(FWD, FWD, 0, LONG);
		wait_flags(ALM, ALM, 0, 0);
		axi_write(ADDR_CTRL, 32'h0000_004A, RESP_OKAY);
		wait_flags(ALM, NONE, 0, 20);
		axi_write(ADDR_CTRL, 32'h0000_000E, RESP_OKAY);
		smp.v_ang[1] <= 9'h0B4;
		wait_flags(FWD | ALM, 19'h0_0060, 0, LONG);
		axi_write(ADDR_CTRL, 32'h0000_000F, RESP_OKAY);
		wait_flags(FWD | ALM, 19'h0_0010, 0, LONG);
		axi_write(ADDR_CTRL, 32'h0000_0002, RESP_OKAY);
		smp.v_ang[1] <= 9'h000;
		wait_flags(FWD, FWD, 0, LONG);
		smp.v_mag[1] <= 16'h0003;
		wait_flags(UNDA, UNDA, 0, 20);
		axi_write(ADDR_TOC, 32'h0104_0064, RESP_OKAY);
		smp.i_mag[0] <= 16'h012C;
		repeat (LONG) @(posedge aclk);
		wait_flags(TOP, NONE, 0, 0);
		axi_write(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
		wait_flags(TOP, TOP, 0, LONG);
		smp.i_mag[0] <= 16'h0000;
		smp.v_mag[1] <= 16'h0064;
		wait_flags(TOP | UNDA, NONE, 0, 20);
		axi_write(ADDR_TOC, 32'h0204_0064, RESP_OKAY);
		smp.i_mag[0] <= 16'h012C;
		repeat (LONG) @(posedge aclk);
		wait_flags(TOP, NONE, 0, 0);
		axi_write(ADDR_TOC, 32'h0104_0064, RESP_OKAY);
		wait_flags(TOP, TOP, 0, LONG);
		axi_read(ADDR_STATUS, 32'h0001_EC70, RESP_OKAY);
		end_of_test();
	end
endmodule : overcurrent_direction_logic_test
